/* File: rtl/cmcl_loader.sv */
// Configuration loader with strap select, serial memory fetch, external shift and preset table.
// Functional notes
// RULE_01 - Keep an 18-bit configuration word, loaded once after each reset release.
// RULE_02 - Strap at release: high external shift, low preset table, floating memory fetch.
// RULE_03 - Reference input chosen by the loaded input select bit.
// RULE_04 - Select 0 means TTL reference, 1 means pseudo-ECL reference.
// RULE_05 - Order: load, PLL acquire, deskew adapt, then lock with all eight stable.
// RULE_06 - Lock output is active high.
// RULE_07 - Reset at any time clears state; reload, relock, lock again.
// RULE_08 - Memory fetch reads the two lowest 16-bit words of a 64x16 memory.
// RULE_09 - Device makes memory clock and address; drives data via strap pin.
// RULE_10 - Board ties memory chip select to reset so it selects after release.
// RULE_11 - External shift captures data on first 18 rising clock edges only.
// RULE_12 - Preset index is preset select high, config clock, serial data.
// RULE_13 - Code 0: PECL, cascade, range 01, divider 0, multiplier 0.
// RULE_14 - Code 1: PECL, cascade, range 10, divider 5, multiplier 2.
// RULE_15 - Code 2: PECL, cascade, range 01, divider 2, multiplier 5.
// RULE_16 - Code 3: PECL, no cascade, range 01, divider 0, multiplier 0.
// RULE_17 - Code 4: TTL, no cascade, range 01, divider 0, multiplier 0.
// RULE_18 - Code 5: TTL, no cascade, range 10, divider 5, multiplier 2.
// RULE_19 - Code 6: TTL, no cascade, range 01, divider 2, multiplier 5.
// RULE_20 - Code 7 sets test; test bypasses the PLL.
// RULE_21 - Cascade bit set for a clock manager reference, cleared for minimum phase.
// RULE_22 - Shift order multiplier, divider, range, cascade, select, test, MSB first.
// RULE_23 - Memory read sends start, read opcode, address zero, then 32 data bits.
`timescale 1ns/1ps

module cmcl_loader #(
   parameter int HALF_CYC = cmcl_pkg::EE_HALF_CYC
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Mode strap pin, shared with the serial memory data input
   input wire logic mode_strap_in,
   input wire logic mode_strap_driven,
   output logic mode_strap_out,
   output logic mode_strap_oe,
   // Configuration clock pin
   input wire logic cfg_clk_in,
   output logic cfg_clk_out,
   output logic cfg_clk_oe,
   // Serial data and preset select
   input wire logic serial_config_data,
   input wire logic preset_select_high,
   // Analog status
   input wire logic pll_locked,
   input wire logic [7:0] deskew_stable,
   // Configuration and status
   output cmcl_pkg::cmcl_cfg_type cfg_o,
   output logic cfg_valid_o,
   output logic ref_sel_pecl,
   output logic cascade_mode,
   output logic pll_bypass,
   output logic lock_o
);

   localparam int HALF_LAST = HALF_CYC - 1;

   cmcl_pkg::cmcl_regs_type q;
   cmcl_pkg::cmcl_regs_type d;
   logic aux_rise;
   logic [cmcl_pkg::PRESET_IDX_W-1:0] rom_idx;

   function automatic logic cmd_bit(input logic [5:0] n);
      cmd_bit = 1'h0;
      if (n < 6'(cmcl_pkg::EE_CMD_BITS)) begin
         cmd_bit = cmcl_pkg::EE_READ_CMD[cmcl_pkg::EE_CMD_BITS - 1 - int'(n)];
      end
   endfunction : cmd_bit

   assign aux_rise = cfg_clk_in && !q.clk_prev;
   // RULE_12 - preset index order
   assign rom_idx = {preset_select_high, cfg_clk_in, serial_config_data};

   always_comb begin
      d = q;
      case (q.st)
         cmcl_pkg::ST_STRAP: begin
            // RULE_02 - strap picks method
            if (!mode_strap_driven) begin
               d.st = cmcl_pkg::ST_EEPROM;
               d.bitcnt = 6'h00;
               d.divcnt = 5'h00;
               d.sck = 1'h0;
               d.di = cmd_bit(6'h00);
            end else if (mode_strap_in) begin
               d.st = cmcl_pkg::ST_AUX;
               d.bitcnt = 6'h00;
               d.clk_prev = cfg_clk_in;
            end else begin
               d.st = cmcl_pkg::ST_ROM;
            end
         end
         cmcl_pkg::ST_ROM: begin
            // RULE_12 - table load
            d.cfg = cmcl_pkg::PRESETS[rom_idx];
            d.cfg_valid = 1'h1;
            d.st = cmcl_pkg::ST_PLL;
         end
         cmcl_pkg::ST_AUX: begin
            d.clk_prev = cfg_clk_in;
            // RULE_11 - first 18 edges
            if (aux_rise) begin
               // RULE_22 - MSB first shift
               d.cfg = {q.cfg[cmcl_pkg::CFG_W-2:0], serial_config_data};
               d.bitcnt = q.bitcnt + 6'h01;
               if (q.bitcnt == 6'(cmcl_pkg::AUX_EDGES - 1)) begin
                  d.cfg_valid = 1'h1;
                  d.st = cmcl_pkg::ST_PLL;
               end
            end
         end
         cmcl_pkg::ST_EEPROM: begin
            // RULE_10 - memory is selected while reset is released, so no select pin here.
            // RULE_09 - self-made memory clock
            if (q.divcnt == 5'(HALF_LAST)) begin
               d.divcnt = 5'h00;
               d.sck = !q.sck;
               if (!q.sck) begin
                  // RULE_08 - sample data words
                  if (q.bitcnt >= 6'(cmcl_pkg::EE_DATA_FIRST)) begin
                     d.cfg = {q.cfg[cmcl_pkg::CFG_W-2:0], serial_config_data};
                  end
                  d.bitcnt = q.bitcnt + 6'h01;
                  if (q.bitcnt == 6'(cmcl_pkg::EE_EDGES - 1)) begin
                     d.sck = 1'h0;
                     d.cfg_valid = 1'h1;
                     d.st = cmcl_pkg::ST_PLL;
                  end
               end else begin
                  // RULE_23 - command bit on falling edge
                  d.di = cmd_bit(q.bitcnt);
               end
            end else begin
               d.divcnt = q.divcnt + 5'h01;
            end
         end
         cmcl_pkg::ST_PLL: begin
            // RULE_05 - wait PLL acquire
            // RULE_20 - test skips PLL
            if (q.cfg.test || pll_locked) begin
               d.st = cmcl_pkg::ST_DESKEW;
            end
         end
         cmcl_pkg::ST_DESKEW: begin
            // RULE_05 - all eight deskewed
            if (&deskew_stable) begin
               d.st = cmcl_pkg::ST_LOCK;
               d.lock = 1'h1;
            end
         end
         cmcl_pkg::ST_LOCK: begin
            d.lock = 1'h1;
         end
         default: begin
            d.st = cmcl_pkg::ST_STRAP;
         end
      endcase
   end

   // RULE_07 - reset clears everything
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   // RULE_01 - held configuration word
   assign cfg_o = q.cfg;
   assign cfg_valid_o = q.cfg_valid;
   // RULE_03 - reference select output
   // RULE_04 - one means PECL
   assign ref_sel_pecl = q.cfg.insel == cmcl_pkg::INSEL_PECL;
   // RULE_21 - cascade bit out
   assign cascade_mode = q.cfg.cascade_mode;
   // RULE_20 - bypass from test bit
   assign pll_bypass = q.cfg.test && q.cfg_valid;
   // RULE_06 - active-high lock
   assign lock_o = q.lock;
   assign cfg_clk_out = q.sck;
   assign cfg_clk_oe = q.st == cmcl_pkg::ST_EEPROM;
   assign mode_strap_out = q.di;
   assign mode_strap_oe = q.st == cmcl_pkg::ST_EEPROM;

   // Assertions are muted while the enable freezes state.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst || !ce);

   sequence s_aux_last;
      q.st == cmcl_pkg::ST_AUX && aux_rise && q.bitcnt == 6'(cmcl_pkg::AUX_EDGES - 1);
   endsequence

   sequence s_ee_begin;
      $rose(mode_strap_oe);
   endsequence

   // Memory clock rise in the command phase; nothing may enter the word there.
   sequence s_ee_cmd_take;
      q.st == cmcl_pkg::ST_EEPROM && q.divcnt == 5'(HALF_LAST) && !q.sck &&
         q.bitcnt < 6'(cmcl_pkg::EE_DATA_FIRST);
   endsequence

   // Memory clock rise in the data phase; the pin is taken into the word.
   sequence s_ee_data_take;
      q.st == cmcl_pkg::ST_EEPROM && q.divcnt == 5'(HALF_LAST) && !q.sck &&
         q.bitcnt >= 6'(cmcl_pkg::EE_DATA_FIRST);
   endsequence

   sequence s_aux_rise;
      q.st == cmcl_pkg::ST_AUX && aux_rise;
   endsequence

   sequence s_aux_idle;
      q.st == cmcl_pkg::ST_AUX && !aux_rise;
   endsequence

   a_lock_order: assert property ($rose(lock_o) |-> $past(&deskew_stable) && cfg_valid_o) // RULE_05
      else $error("lock rose without deskew or config");

   a_lock_sticky: assert property (lock_o |=> lock_o) // RULE_06
      else $error("lock dropped without reset");

   a_rom_index: assert property ((q.st == cmcl_pkg::ST_ROM) |=> // RULE_12
      cfg_o == cmcl_pkg::PRESETS[$past(rom_idx)] && cfg_valid_o)
      else $error("preset load wrong");

   a_aux_limit: assert property (s_aux_last |=> q.st == cmcl_pkg::ST_PLL && cfg_valid_o) // RULE_11
      else $error("external shift not closed after 18 edges");

   a_ee_half: assert property ($rose(cfg_clk_out) |-> $past(q.divcnt) == 5'(HALF_LAST)) // RULE_09
      else $error("memory clock half period wrong");

   a_ee_start: assert property (s_ee_begin |-> mode_strap_out ##1 (!cfg_clk_out) [*8]) // RULE_23
      else $error("memory read did not start with start bit");

   a_test_skip: assert property ((q.st == cmcl_pkg::ST_PLL && q.cfg.test) |=> // RULE_20
      q.st == cmcl_pkg::ST_DESKEW)
      else $error("test mode did not bypass PLL wait");

   a_strap_pick: assert property ( // RULE_02
      (q.st == cmcl_pkg::ST_STRAP && !mode_strap_driven) |=> mode_strap_oe && cfg_clk_oe)
      else $error("floating strap did not start memory fetch");

   a_ee_done: assert property (($rose(cfg_valid_o) && $past(mode_strap_oe)) |-> // RULE_08
      q.bitcnt == 6'(cmcl_pkg::EE_EDGES))
      else $error("memory fetch ended on wrong edge count");

   a_load_once: assert property (cfg_valid_o |=> $stable(cfg_o) && cfg_valid_o) // RULE_01
      else $error("configuration changed after load");

   // Memory command bits, checked as each memory clock rise lands.
   a_ee_cmd_bits: assert property ( // RULE_23
      ($rose(cfg_clk_out) && q.bitcnt <= 6'(cmcl_pkg::EE_CMD_BITS)) |->
      mode_strap_out == cmcl_pkg::EE_READ_CMD[cmcl_pkg::EE_CMD_BITS - int'(q.bitcnt)])
      else $error("memory command bit wrong");

   a_ee_cmd_tail: assert property ( // RULE_08
      ($rose(cfg_clk_out) && q.bitcnt > 6'(cmcl_pkg::EE_CMD_BITS)) |-> !mode_strap_out)
      else $error("memory data input not low after address zero");

   a_ee_half_low: assert property ( // RULE_09
      $fell(cfg_clk_out) |-> $past(q.divcnt) == 5'(HALF_LAST))
      else $error("memory clock high time wrong");

   a_ee_clock_idle: assert property ( // RULE_09
      !mode_strap_oe |-> !cfg_clk_out)
      else $error("memory clock moved outside fetch");

   a_ee_cmd_hold: assert property ( // RULE_08
      s_ee_cmd_take |=> $stable(cfg_o))
      else $error("command phase bit entered the configuration");

   a_ee_data_shift: assert property ( // RULE_08
      s_ee_data_take |=> cfg_o.test == $past(serial_config_data))
      else $error("memory data bit not taken at clock rise");

   a_ee_count: assert property ( // RULE_23
      (q.st == cmcl_pkg::ST_EEPROM && q.divcnt == 5'(HALF_LAST) && !q.sck) |=>
      q.bitcnt == $past(q.bitcnt) + 6'h01)
      else $error("memory clock rise not counted");

   a_oe_release: assert property ( // RULE_09
      $fell(mode_strap_oe) |-> $rose(cfg_valid_o) && !cfg_clk_out)
      else $error("memory pins released before the word was complete");

   a_aux_count: assert property ( // RULE_11
      s_aux_rise |=> q.bitcnt == $past(q.bitcnt) + 6'h01)
      else $error("external shift edge not counted");

   a_aux_shift: assert property ( // RULE_22
      s_aux_rise |=> cfg_o.test == $past(serial_config_data))
      else $error("external shift bit not taken at clock rise");

   a_aux_idle: assert property ( // RULE_11
      s_aux_idle |=> $stable(cfg_o))
      else $error("configuration moved without a clock rise");

   a_strap_aux: assert property ( // RULE_02
      (q.st == cmcl_pkg::ST_STRAP && mode_strap_driven && mode_strap_in) |=>
      q.st == cmcl_pkg::ST_AUX)
      else $error("high strap did not start external shift");

   a_strap_rom: assert property ( // RULE_02
      (q.st == cmcl_pkg::ST_STRAP && mode_strap_driven && !mode_strap_in) |=>
      q.st == cmcl_pkg::ST_ROM)
      else $error("low strap did not start preset load");

   // Until the strap is taken nothing of an earlier load may show.
   a_strap_clean: assert property ( // RULE_07
      q.st == cmcl_pkg::ST_STRAP |->
      cfg_o == cmcl_pkg::CFG_RESET && !cfg_valid_o && !lock_o)
      else $error("state survived reset");

   a_rom_leave: assert property ( // RULE_12
      q.st == cmcl_pkg::ST_ROM |=> q.st == cmcl_pkg::ST_PLL)
      else $error("preset load took more than one cycle");

   a_pll_wait: assert property ( // RULE_05
      (q.st == cmcl_pkg::ST_PLL && !q.cfg.test && !pll_locked) |=>
      q.st == cmcl_pkg::ST_PLL)
      else $error("PLL wait left before lock");

   a_pll_go: assert property ( // RULE_05
      (q.st == cmcl_pkg::ST_PLL && pll_locked) |=> q.st == cmcl_pkg::ST_DESKEW)
      else $error("locked PLL did not move on to deskew");

   a_deskew_wait: assert property ( // RULE_05
      (q.st == cmcl_pkg::ST_DESKEW && !(&deskew_stable)) |=> !lock_o)
      else $error("lock with a channel still adapting");

   a_lock_valid: assert property ( // RULE_05
      lock_o |-> cfg_valid_o && !mode_strap_oe)
      else $error("lock without a loaded configuration");

   a_lock_source: assert property ( // RULE_05
      $rose(lock_o) |-> $past(q.st) == cmcl_pkg::ST_DESKEW)
      else $error("lock rose outside the deskew wait");

   a_deskew_loaded: assert property ( // RULE_01
      q.st == cmcl_pkg::ST_DESKEW |-> cfg_valid_o)
      else $error("deskew wait entered without configuration");

   a_valid_first: assert property ( // RULE_05
      $rose(cfg_valid_o) |-> !lock_o)
      else $error("lock before configuration load");

endmodule : cmcl_loader

/* File: pkg/cmcl_pkg.sv */
// Package of constants, field layout, preset table and state types of the config loader.
package cmcl_pkg;

   // Configuration word, most significant field shifted in first.
   typedef struct packed {
      logic [6:0] mult;
      logic [5:0] div;
      logic [1:0] range_field;
      logic cascade_mode;
      logic insel;
      logic test;
   } cmcl_cfg_type;

   localparam int CFG_W = 18;
   localparam int MULT_POS = 11;
   localparam int DIV_POS = 5;
   localparam int RANGE_POS = 3;
   localparam int CASCADE_POS = 2;
   localparam int INSEL_POS = 1;
   localparam int TEST_POS = 0;
   localparam logic [CFG_W-1:0] CFG_RESET = 18'h00000;

   // Input select encoding.
   localparam logic INSEL_TTL = 1'h0;
   localparam logic INSEL_PECL = 1'h1;

   // Timing of the serial memory clock.
   localparam int SYS_CLK_NS = 40;
   localparam int EE_HALF_NS = 900;
   localparam int EE_HALF_CYC = (EE_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   // Serial memory read: start bit, read opcode, address zero, then a dummy bit.
   localparam int EE_CMD_BITS = 9;
   localparam logic [EE_CMD_BITS-1:0] EE_READ_CMD = 9'h180;
   localparam int EE_DATA_FIRST = 10;
   localparam int EE_EDGES = 42;
   localparam int AUX_EDGES = 18;

   localparam int PRESET_NUM = 8;
   localparam int PRESET_IDX_W = 3;
   // {mult, div, range, cascade, insel, test}
   localparam logic [CFG_W-1:0] PRESETS [PRESET_NUM] = '{
      // RULE_13 - code zero
      {7'h00, 6'h00, 2'h1, 1'h1, INSEL_PECL, 1'h0},
      // RULE_14 - code one
      {7'h02, 6'h05, 2'h2, 1'h1, INSEL_PECL, 1'h0},
      // RULE_15 - code two
      {7'h05, 6'h02, 2'h1, 1'h1, INSEL_PECL, 1'h0},
      // RULE_16 - code three
      {7'h00, 6'h00, 2'h1, 1'h0, INSEL_PECL, 1'h0},
      // RULE_17 - code four
      {7'h00, 6'h00, 2'h1, 1'h0, INSEL_TTL, 1'h0},
      // RULE_18 - code five
      {7'h02, 6'h05, 2'h2, 1'h0, INSEL_TTL, 1'h0},
      // RULE_19 - code six
      {7'h05, 6'h02, 2'h1, 1'h0, INSEL_TTL, 1'h0},
      // RULE_20 - code seven test
      {7'h00, 6'h00, 2'h1, 1'h0, INSEL_TTL, 1'h1}
   };

   typedef enum logic [2:0] {
      ST_STRAP,
      ST_EEPROM,
      ST_AUX,
      ST_ROM,
      ST_PLL,
      ST_DESKEW,
      ST_LOCK
   } cmcl_state_type;

   typedef struct packed {
      cmcl_state_type st;
      cmcl_cfg_type cfg;
      logic cfg_valid;
      logic [5:0] bitcnt;
      logic [4:0] divcnt;
      logic sck;
      logic di;
      logic clk_prev;
      logic lock;
   } cmcl_regs_type;

endpackage : cmcl_pkg

/* File: sim/cmcl_eeprom_model.sv */
// Behavioural three-wire serial memory holding the two lowest configuration words.
`timescale 1ns/1ps
module cmcl_eeprom_model (
   // Memory pins
   input wire logic cs,
   input wire logic sk,
   input wire logic di,
   output logic do_o,
   // Stored words and captured command
   input wire logic [15:0] word0,
   input wire logic [15:0] word1,
   output logic [8:0] cmd
);
   int n = 0;
   logic [31:0] words;
   assign words = {word0, word1};
   initial do_o = 1'h0;
   initial cmd = 9'h000;
   always @(posedge sk or negedge cs) begin
      if (!cs) begin
         n <= 0;
         do_o <= ~do_o;
      end else begin
         n <= n + 1;
         if (n < 9) cmd <= {cmd[7:0], di};
         // Outside the data phase the line toggles, so a stale bit is never read as valid.
         if (n >= 9 && n <= 40) do_o <= words[40-n];
         else do_o <= ~do_o;
      end
   end
endmodule : cmcl_eeprom_model

/* File: sim/testbench.sv */
// Self-checking bench of the configuration loader in all three load modes.
`timescale 1ns/1ps
module testbench;
   logic clk, sys_rst, tb_drv, tb_strap, tb_clk, tb_data, psel, pll_locked, eep_sel, ce_in;
   logic strap_out, strap_oe, clk_out, clk_oe, ee_do, strap_pin, clk_pin, data_pin;
   logic cfg_valid_o, ref_sel_pecl, cascade_mode, pll_bypass, lock_o;
   logic [7:0] deskew_stable;
   logic [8:0] ee_cmd;
   logic [15:0] w0, w1;
   logic [17:0] exp_v;
   cmcl_pkg::cmcl_cfg_type cfg_o;
   logic [17:0] rom_tbl [8] = '{18'h0000E, 18'h010B6, 18'h0284E, 18'h0000A,
                                18'h00008, 18'h010B0, 18'h02848, 18'h00009};
   int error_cnt, checks, i, k;
   assign strap_pin = strap_oe ? strap_out : tb_strap;
   assign clk_pin = clk_oe ? clk_out : tb_clk;
   assign data_pin = eep_sel ? ee_do : tb_data;
   // A short memory clock keeps the run brief, yet each half still spans nine cycles.
   cmcl_loader #(.HALF_CYC(9)) dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce_in),
      .mode_strap_in(strap_pin), .mode_strap_driven(tb_drv), .mode_strap_out(strap_out),
      .mode_strap_oe(strap_oe), .cfg_clk_in(clk_pin), .cfg_clk_out(clk_out),
      .cfg_clk_oe(clk_oe), .serial_config_data(data_pin), .preset_select_high(psel),
      .pll_locked(pll_locked), .deskew_stable(deskew_stable), .cfg_o(cfg_o),
      .cfg_valid_o(cfg_valid_o), .ref_sel_pecl(ref_sel_pecl), .cascade_mode(cascade_mode),
      .pll_bypass(pll_bypass), .lock_o(lock_o));
   cmcl_eeprom_model ee_u (.cs(~sys_rst), .sk(clk_out), .di(strap_pin), .do_o(ee_do),
      .word0(w0), .word1(w1), .cmd(ee_cmd));
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   task chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task final_report;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   task wait_hi(input logic lk, input int lim);
      int n;
      n = 0;
      while (((lk ? lock_o : cfg_valid_o) !== 1'b1) && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         error_cnt++;
         $display("[FAIL] wait expected 1 seen 0");
         final_report();
      end
   endtask : wait_hi
   task start(input logic drv, input logic st, input logic [2:0] idx);
      @(negedge clk);
      sys_rst = 1'h1;
      pll_locked = 1'h0;
      deskew_stable = 8'h00;
      tb_drv = drv;
      tb_strap = st;
      eep_sel = ~drv;
      {psel, tb_clk, tb_data} = idx;
      repeat (4) @(negedge clk);
      chk("lock in reset", {17'h0, lock_o}, 18'h0);
      chk("cfg in reset", cfg_o, 18'h0);
      sys_rst = 1'h0;
   endtask : start
   task lock_seq;
      deskew_stable = 8'hFF ^ (8'h01 << ($urandom % 8));
      repeat (8) @(negedge clk);
      pll_locked = 1'h1;
      repeat (8) @(negedge clk);
      chk("lock with channel unstable", {17'h0, lock_o}, 18'h0);
      deskew_stable = 8'hFF;
      wait_hi(1'h1, 20);
      chk("lock", {17'h0, lock_o}, 18'h1);
   endtask : lock_seq
   initial begin
      sys_rst = 1'h1;
      {tb_drv, tb_strap, tb_clk, tb_data, psel, pll_locked, eep_sel} = 7'h40;
      deskew_stable = 8'h00;
      ce_in = 1'h1;
      w0 = 16'h0000;
      w1 = 16'h0000;
      error_cnt = 0;
      checks = 0;
      k = $urandom(3943);
      for (i = 0; i < 8; i++) begin
         start(1'h1, 1'h0, i[2:0]);
         wait_hi(1'h0, 20);
         chk("preset cfg", cfg_o, rom_tbl[i]);
         chk("ref select", {17'h0, ref_sel_pecl}, {17'h0, rom_tbl[i][1]});
         chk("cascade", {17'h0, cascade_mode}, {17'h0, rom_tbl[i][2]});
         chk("bypass", {17'h0, pll_bypass}, {17'h0, rom_tbl[i][0]});
         lock_seq();
         $display("preset code %0d test done", i);
      end
      start(1'h1, 1'h1, 3'h0);
      exp_v = 18'($urandom);
      // Four extra clock rises carry inverted data and must be ignored.
      for (i = 0; i < 22; i++) begin
         tb_data = (i < 18) ? exp_v[17-i] : ~exp_v[0];
         repeat (2) @(negedge clk);
         tb_clk = 1'h1;
         repeat (2) @(negedge clk);
         tb_clk = 1'h0;
      end
      chk("shift cfg", cfg_o, exp_v);
      lock_seq();
      $display("external shift test done");
      w0 = 16'($urandom);
      w1 = 16'($urandom);
      start(1'h0, 1'h0, 3'h0);
      wait_hi(1'h0, 1000);
      chk("memory cfg", cfg_o, {w0[1:0], w1});
      chk("memory command", {9'h0, ee_cmd}, 18'h00180);
      chk("memory clock released", {17'h0, clk_oe}, 18'h0);
      chk("memory data line released", {17'h0, strap_oe}, 18'h0);
      lock_seq();
      $display("memory fetch test done");
      start(1'h0, 1'h0, 3'h0);
      repeat (40) @(negedge clk);
      k = $urandom % 8;
      start(1'h1, 1'h0, k[2:0]);
      // With the enable low the strap must not even be taken.
      ce_in = 1'h0;
      repeat (10) @(negedge clk);
      chk("frozen while disabled", {17'h0, cfg_valid_o}, 18'h0);
      ce_in = 1'h1;
      wait_hi(1'h0, 20);
      chk("reload cfg", cfg_o, rom_tbl[k]);
      lock_seq();
      $display("reset abort test done");
      final_report();
   end
endmodule : testbench
